/* dswc_pkg.sv */
// Constants shared by the deep sleep wake control block.
// Assumes a 250 MHz always-on clock and an AXI4-Lite register bus.
package dswc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned POR_PULSE_NS = 100;
  localparam int unsigned POR_PULSE_CYC = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] POR_CNT_LAST = 5'(POR_PULSE_CYC - 1);

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int PIN_W = 8;
  localparam int CTX_W = 16;
  localparam int WK_W = 6;
  localparam logic [7:0] PIN_DIR_RST = 8'hff;
  localparam logic [7:0] PIN_LAT_RST = 8'h00;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_DS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RST_CTRL = 8'h04;
  localparam logic [7:0] OFS_WAKE_SRC = 8'h08;
  localparam logic [7:0] OFS_CTX0 = 8'h0c;
  localparam logic [7:0] OFS_CTX1 = 8'h10;
  localparam logic [7:0] OFS_CFG = 8'h14;
  localparam logic [7:0] OFS_PIN_DIR = 8'h18;
  localparam logic [7:0] OFS_PIN_LAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_PEND = 8'h20;
  localparam logic [7:0] OFS_OSC_CTRL = 8'h24;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_RELEASE = 0;
  localparam int BIT_BOR_FLAG = 1;
  localparam int BIT_DS_EN = 15;
  localparam int BIT_DS_EXIT = 10;
  localparam int BIT_RTC_EN = 0;
  localparam int BIT_EXT_INTERRUPT_PIN_ZERO_EN = 1;
  localparam int BIT_EXT_INTERRUPT_PIN_ZERO_POL = 2;
  localparam int BIT_BOR_EN = 3;
  localparam int BIT_SECONDARY_OSCILLATOR_EN = 1;
  localparam int WK_POR = 0;
  localparam int WK_WDT = 1;
  localparam int WK_RTC = 2;
  localparam int WK_MASTER_CLEAR_PIN = 3;
  localparam int WK_EXT_INTERRUPT_PIN_ZERO = 4;
  localparam int WK_BOR = 5;
  localparam logic [5:0] MASTER_CLEAR_PIN_INV = 6'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE = 2'b10
  } dswc_state_type;

endpackage

/* dswc_pin_if.sv */
// Carrier between the controller and the pin hold stage.
// Assumes both ends run on the same clock.
interface dswc_pin_if;
  logic [dswc_pkg::PIN_W-1:0] dir;
  logic [dswc_pkg::PIN_W-1:0] lat;
  logic [dswc_pkg::PIN_W-1:0] pin_out;
  logic [dswc_pkg::PIN_W-1:0] pin_oe;
  logic held;
  logic capture;
  modport ctl (output dir, lat, held, capture, input pin_out, pin_oe);
  modport hold (input dir, lat, held, capture, output pin_out, pin_oe);
endinterface

/* dswc_sync.sv */
// Two-stage synchroniser for the asynchronous wake inputs.
// Assumes inputs may change at any time relative to clk.
module dswc_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [dswc_pkg::WK_W-1:0] d,
  output logic [dswc_pkg::WK_W-1:0] q
);
  typedef struct packed {
    logic [dswc_pkg::WK_W-1:0] s1;
    logic [dswc_pkg::WK_W-1:0] s2;
  } dswc_sync_state_type;

  dswc_sync_state_type s_r;
  dswc_sync_state_type s_nxt;

  always_comb
  begin
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk)
  begin
    // Reset to the idle pin levels so that no false master clear follows reset
    if (!reset_n)
      s_r <= {dswc_pkg::MASTER_CLEAR_PIN_INV, dswc_pkg::MASTER_CLEAR_PIN_INV};
    else if (ce)
      s_r <= s_nxt;
  end

  assign q = s_r.s2;
endmodule

/* dswc_pinhold.sv */
// Pin hold stage: freezes pin drive at sleep entry until release.
// Assumes capture pulses in the first cycle that held is high.
module dswc_pinhold (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  dswc_pin_if.hold pif
);
  typedef struct packed {
    logic [dswc_pkg::PIN_W-1:0] h_oe;
    logic [dswc_pkg::PIN_W-1:0] h_out;
    logic [dswc_pkg::PIN_W-1:0] oe;
    logic [dswc_pkg::PIN_W-1:0] out;
  } dswc_hold_state_type;

  dswc_hold_state_type s_r;
  dswc_hold_state_type s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (pif.capture)
    begin
      s_nxt.h_oe = ~pif.dir;
      s_nxt.h_out = pif.lat;
    end
    if (pif.held)
    begin
      s_nxt.oe = s_nxt.h_oe;
      s_nxt.out = s_nxt.h_out;
    end
    else
    begin
      s_nxt.oe = ~pif.dir;
      s_nxt.out = pif.lat;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s_r <= '0;
    else if (ce)
      s_r <= s_nxt;
  end

  assign pif.pin_out = s_r.out;
  assign pif.pin_oe = s_r.oe;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_pin_hold: assert property (@(posedge clk) disable iff (!reset_n)
    ce && pif.held && !pif.capture |=> $stable(pif.pin_oe) && $stable(pif.pin_out))
    else $error("held pins changed");
  a_release_follow: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !pif.held |=> pif.pin_oe == ~$past(pif.dir) && pif.pin_out == $past(pif.lat))
    else $error("released pins do not follow registers");
  a_entry_drive: assert property (@(posedge clk) disable iff (!reset_n)
    ce && pif.capture && pif.held |=> pif.pin_oe == ~$past(pif.dir))
    else $error("entry drive not captured");
endmodule

/* dswc_top.sv */
// Deep sleep wake control: wake detection, reset request, context
// registers and pin hold, reached over AXI4-Lite.
// Assumes an always-on clock reset only by a true POR or brown-out.
//
// Contract
// - Main supply POR event wakes from sleep
// - Watchdog time-out wakes from sleep
// - Clock alarm wakes only when enabled
// - Master clear pin low wakes
// - Interrupt pin wakes if armed, polarity, changed
// - Entry clears all pending interrupt requests
// - Wake is full reset, context kept
// - Wake source records from enable to release
// - Wake clears enable, restarts at vector
// - Exit flag bit 10, software clears
// - Brown-out in sleep sets bit 1
// - Context registers survive deep sleep
// - Sleep pins keep entry direction, level
// - After wake pins stay held, regs reset
// - Release clear applies current pin registers
// - Enabled brown-out or POR releases, loses context
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
module dswc_top (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic POR_EVENT,
  input wire logic WDT_TIMEOUT,
  input wire logic RTC_ALARM,
  input wire logic MASTER_CLEAR_PIN_N,
  input wire logic EXT_INTERRUPT_PIN_ZERO,
  input wire logic BROWNOUT,
  input wire logic [7:0] IRQ_REQ,
  output logic SYS_RESET,
  output logic DEEP_SLEEP,
  output logic SECONDARY_OSCILLATOR_EN,
  output logic [dswc_pkg::PIN_W-1:0] PIN_OUT,
  output logic [dswc_pkg::PIN_W-1:0] PIN_OE
);
  typedef struct packed {
    dswc_pkg::dswc_state_type st;
    logic [4:0] cnt;
    logic rec;
    logic held;
    logic capture;
    logic bor_flag;
    logic deep_sleep_enable_bit;
    logic exit_flag;
    logic rtc_en;
    logic ext_interrupt_pin_zero_en;
    logic ext_interrupt_pin_zero_pol;
    logic bor_en;
    logic secondary_oscillator;
    logic secondary_oscillator_hold;
    logic ext_interrupt_pin_zero_arm;
    logic ext_interrupt_pin_zero_lvl;
    logic ext_interrupt_pin_zero_chg;
    logic [dswc_pkg::WK_W-1:0] wake;
    logic [dswc_pkg::CTX_W-1:0] ctx0;
    logic [dswc_pkg::CTX_W-1:0] ctx1;
    logic [7:0] dir;
    logic [7:0] lat;
    logic [7:0] irq;
    logic aw_full;
    logic w_full;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dswc_top_state_type;

  dswc_top_state_type s_r;
  dswc_top_state_type s_nxt;
  logic [dswc_pkg::WK_W-1:0] ev_s;
  logic [dswc_pkg::WK_W-1:0] evt;
  logic [dswc_pkg::WK_W-1:0] rec_v;
  logic ext_interrupt_pin_zero_hit;
  logic wake_any;
  logic [32:0] wr_old;
  logic [32:0] rd_res;
  logic [31:0] d;
  logic [31:0] wm;

  dswc_pin_if pif ();

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic dswc_top_state_type rst_val();
    dswc_top_state_type v;
    v = '0;
    v.st = dswc_pkg::ST_RUN;
    v.dir = dswc_pkg::PIN_DIR_RST;
    v.lat = dswc_pkg::PIN_LAT_RST;
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  // Returns {hit, word}; an unmapped or unaligned address misses
  function automatic logic [32:0] rd_word(input dswc_top_state_type s, input logic [7:0] a);
    logic [31:0] w;
    logic hit;
    w = '0;
    hit = 1'b1;
    case (a)
      dswc_pkg::OFS_DS_CTRL:
      begin
        w[dswc_pkg::BIT_RELEASE] = s.held;
        w[dswc_pkg::BIT_BOR_FLAG] = s.bor_flag;
        w[dswc_pkg::BIT_DS_EN] = s.deep_sleep_enable_bit;
      end
      dswc_pkg::OFS_RST_CTRL: w[dswc_pkg::BIT_DS_EXIT] = s.exit_flag;
      dswc_pkg::OFS_WAKE_SRC: w[dswc_pkg::WK_W-1:0] = s.wake;
      dswc_pkg::OFS_CTX0: w[dswc_pkg::CTX_W-1:0] = s.ctx0;
      dswc_pkg::OFS_CTX1: w[dswc_pkg::CTX_W-1:0] = s.ctx1;
      dswc_pkg::OFS_CFG:
      begin
        w[dswc_pkg::BIT_RTC_EN] = s.rtc_en;
        w[dswc_pkg::BIT_EXT_INTERRUPT_PIN_ZERO_EN] = s.ext_interrupt_pin_zero_en;
        w[dswc_pkg::BIT_EXT_INTERRUPT_PIN_ZERO_POL] = s.ext_interrupt_pin_zero_pol;
        w[dswc_pkg::BIT_BOR_EN] = s.bor_en;
      end
      dswc_pkg::OFS_PIN_DIR: w[7:0] = s.dir;
      dswc_pkg::OFS_PIN_LAT: w[7:0] = s.lat;
      dswc_pkg::OFS_IRQ_PEND: w[7:0] = s.irq;
      dswc_pkg::OFS_OSC_CTRL: w[dswc_pkg::BIT_SECONDARY_OSCILLATOR_EN] = s.secondary_oscillator;
      default: hit = 1'b0;
    endcase
    return {hit, w};
  endfunction

  // ---------------------------------------------------------------
  // Wake inputs
  // ---------------------------------------------------------------
  dswc_sync u_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .ce(CE),
    .d({BROWNOUT, EXT_INTERRUPT_PIN_ZERO, MASTER_CLEAR_PIN_N, RTC_ALARM, WDT_TIMEOUT, POR_EVENT}),
    .q(ev_s)
  );

  // Master clear is active low; flip it only after synchronising
  assign evt = ev_s ^ dswc_pkg::MASTER_CLEAR_PIN_INV;

  // A change is needed, so a pin already at the wake level does not fire
  assign ext_interrupt_pin_zero_hit = s_r.ext_interrupt_pin_zero_arm && (s_r.ext_interrupt_pin_zero_chg || evt[dswc_pkg::WK_EXT_INTERRUPT_PIN_ZERO] != s_r.ext_interrupt_pin_zero_lvl)
    && evt[dswc_pkg::WK_EXT_INTERRUPT_PIN_ZERO] == s_r.ext_interrupt_pin_zero_pol;
  always_comb
  begin
    rec_v = '0;
    rec_v[dswc_pkg::WK_POR] = evt[dswc_pkg::WK_POR];
    rec_v[dswc_pkg::WK_WDT] = evt[dswc_pkg::WK_WDT];
    rec_v[dswc_pkg::WK_RTC] = evt[dswc_pkg::WK_RTC] && s_r.rtc_en;
    rec_v[dswc_pkg::WK_MASTER_CLEAR_PIN] = evt[dswc_pkg::WK_MASTER_CLEAR_PIN];
    rec_v[dswc_pkg::WK_EXT_INTERRUPT_PIN_ZERO] = ext_interrupt_pin_zero_hit;
    rec_v[dswc_pkg::WK_BOR] = evt[dswc_pkg::WK_BOR];
  end
  assign wake_any = |rec_v[dswc_pkg::WK_EXT_INTERRUPT_PIN_ZERO:dswc_pkg::WK_POR];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  assign wr_old = rd_word(s_r, s_r.awaddr);
  assign rd_res = rd_word(s_r, ARADDR);
  assign d = merge(wr_old[31:0], s_r.wdata, s_r.wstrb);
  assign wm = merge('0, s_r.wdata, s_r.wstrb);

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.capture = 1'b0;
    if (AWVALID && AWREADY)
    begin
      s_nxt.aw_full = 1'b1;
      s_nxt.awaddr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      s_nxt.w_full = 1'b1;
      s_nxt.wdata = WDATA;
      s_nxt.wstrb = WSTRB;
    end
    if (s_r.bvalid && BREADY)
      s_nxt.bvalid = 1'b0;
    if (s_r.aw_full && s_r.w_full)
    begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr_old[32] ? dswc_pkg::RESP_OKAY : dswc_pkg::RESP_SLVERR;
      case (s_r.awaddr)
        dswc_pkg::OFS_DS_CTRL:
        begin
          if (!d[dswc_pkg::BIT_RELEASE])
          begin
            s_nxt.held = 1'b0;
            s_nxt.rec = 1'b0;
          end
          if (!d[dswc_pkg::BIT_BOR_FLAG])
            s_nxt.bor_flag = 1'b0;
          if (d[dswc_pkg::BIT_DS_EN] && s_r.st == dswc_pkg::ST_RUN)
          begin
            s_nxt.deep_sleep_enable_bit = 1'b1;
            s_nxt.rec = 1'b1;
            s_nxt.wake = '0;
          end
        end
        dswc_pkg::OFS_RST_CTRL:
          if (!d[dswc_pkg::BIT_DS_EXIT])
            s_nxt.exit_flag = 1'b0;
        dswc_pkg::OFS_WAKE_SRC: s_nxt.wake = s_r.wake & ~wm[dswc_pkg::WK_W-1:0];
        dswc_pkg::OFS_CTX0: s_nxt.ctx0 = d[dswc_pkg::CTX_W-1:0];
        dswc_pkg::OFS_CTX1: s_nxt.ctx1 = d[dswc_pkg::CTX_W-1:0];
        dswc_pkg::OFS_CFG:
        begin
          s_nxt.rtc_en = d[dswc_pkg::BIT_RTC_EN];
          s_nxt.ext_interrupt_pin_zero_en = d[dswc_pkg::BIT_EXT_INTERRUPT_PIN_ZERO_EN];
          s_nxt.ext_interrupt_pin_zero_pol = d[dswc_pkg::BIT_EXT_INTERRUPT_PIN_ZERO_POL];
          s_nxt.bor_en = d[dswc_pkg::BIT_BOR_EN];
        end
        dswc_pkg::OFS_PIN_DIR: s_nxt.dir = d[7:0];
        dswc_pkg::OFS_PIN_LAT: s_nxt.lat = d[7:0];
        dswc_pkg::OFS_IRQ_PEND: s_nxt.irq = s_r.irq & ~wm[7:0];
        dswc_pkg::OFS_OSC_CTRL: s_nxt.secondary_oscillator = d[dswc_pkg::BIT_SECONDARY_OSCILLATOR_EN];
        default: ;
      endcase
    end
    if (s_r.rvalid && RREADY)
      s_nxt.rvalid = 1'b0;
    if (ARVALID && ARREADY)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_res[31:0];
      s_nxt.rresp = rd_res[32] ? dswc_pkg::RESP_OKAY : dswc_pkg::RESP_SLVERR;
    end

    // Hardware sets come after software clears so that a set wins
    s_nxt.irq = s_nxt.irq | IRQ_REQ;
    if (s_r.rec)
      s_nxt.wake = s_nxt.wake | rec_v;

    unique case (s_r.st)
      dswc_pkg::ST_RUN:
        if (s_r.deep_sleep_enable_bit)
        begin
          s_nxt.st = dswc_pkg::ST_SLEEP;
          s_nxt.held = 1'b1;
          s_nxt.capture = 1'b1;
          s_nxt.secondary_oscillator_hold = s_r.secondary_oscillator;
          s_nxt.irq = '0;
          s_nxt.ext_interrupt_pin_zero_arm = s_r.ext_interrupt_pin_zero_en;
          s_nxt.ext_interrupt_pin_zero_lvl = evt[dswc_pkg::WK_EXT_INTERRUPT_PIN_ZERO];
          s_nxt.ext_interrupt_pin_zero_chg = 1'b0;
        end
      dswc_pkg::ST_SLEEP:
      begin
        if (evt[dswc_pkg::WK_EXT_INTERRUPT_PIN_ZERO] != s_r.ext_interrupt_pin_zero_lvl)
          s_nxt.ext_interrupt_pin_zero_chg = 1'b1;
        if (evt[dswc_pkg::WK_BOR])
          s_nxt.bor_flag = 1'b1;
        if (s_r.bor_en && (evt[dswc_pkg::WK_BOR] || evt[dswc_pkg::WK_POR]))
        begin
          s_nxt.held = 1'b0;
          s_nxt.ctx0 = '0;
          s_nxt.ctx1 = '0;
        end
        if (wake_any)
        begin
          s_nxt.st = dswc_pkg::ST_WAKE;
          s_nxt.cnt = '0;
          s_nxt.deep_sleep_enable_bit = 1'b0;
          s_nxt.exit_flag = 1'b1;
          s_nxt.dir = dswc_pkg::PIN_DIR_RST;
          s_nxt.lat = dswc_pkg::PIN_LAT_RST;
          s_nxt.secondary_oscillator = 1'b0;
        end
      end
      dswc_pkg::ST_WAKE:
      begin
        s_nxt.cnt = s_r.cnt + 5'h01;
        if (s_r.cnt == dswc_pkg::POR_CNT_LAST)
          s_nxt.st = dswc_pkg::ST_RUN;
      end
      default: s_nxt.st = dswc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      s_r <= rst_val();
    else if (CE)
      s_r <= s_nxt;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Context registers and the clock alarm path sit outside this reset
  assign SYS_RESET = s_r.st == dswc_pkg::ST_WAKE;
  assign DEEP_SLEEP = s_r.st == dswc_pkg::ST_SLEEP;
  assign SECONDARY_OSCILLATOR_EN = s_r.held ? s_r.secondary_oscillator_hold : s_r.secondary_oscillator;
  assign AWREADY = !s_r.aw_full && !s_r.bvalid;
  assign WREADY = !s_r.w_full && !s_r.bvalid;
  assign BVALID = s_r.bvalid;
  assign BRESP = s_r.bresp;
  assign ARREADY = !s_r.rvalid;
  assign RVALID = s_r.rvalid;
  assign RDATA = s_r.rdata;
  assign RRESP = s_r.rresp;
  assign pif.dir = s_r.dir;
  assign pif.lat = s_r.lat;
  assign pif.held = s_r.held;
  assign pif.capture = s_r.capture;
  assign PIN_OUT = pif.pin_out;
  assign PIN_OE = pif.pin_oe;

  dswc_pinhold u_hold (
    .clk(CLK),
    .reset_n(RESET_N),
    .ce(CE),
    .pif(pif.hold)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  localparam int POR_HOLD_CYC = dswc_pkg::POR_PULSE_CYC - 1;

  default clocking dswc_cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_wake_por: assert property (CE && DEEP_SLEEP && evt[dswc_pkg::WK_POR] |=> SYS_RESET)
    else $error("POR did not wake");
  a_wake_wdt: assert property (CE && DEEP_SLEEP && evt[dswc_pkg::WK_WDT] |=> SYS_RESET)
    else $error("watchdog did not wake");
  a_rtc_gate: assert property (CE && DEEP_SLEEP && !wake_any |=> DEEP_SLEEP)
    else $error("wake without an enabled source");
  a_wake_master_clear_pin: assert property (CE && DEEP_SLEEP && evt[dswc_pkg::WK_MASTER_CLEAR_PIN] |=> SYS_RESET)
    else $error("master clear did not wake");
  a_entry_clear: assert property (CE && s_r.capture |-> s_r.irq == '0 && s_r.held)
    else $error("entry left irq pending or pins free");
  a_reset_len: assert property (CE && $rose(SYS_RESET) |-> ##POR_HOLD_CYC SYS_RESET)
    else $error("reset pulse too short");
  a_ctx_keep: assert property (CE && DEEP_SLEEP && !s_r.bor_en |=> $stable(s_r.ctx0) && $stable(s_r.ctx1))
    else $error("context lost in sleep");
  a_wake_record: assert property (CE && s_r.rec && evt[dswc_pkg::WK_WDT] |=> s_r.wake[dswc_pkg::WK_WDT])
    else $error("wake source not recorded");
  a_exit_flags: assert property (CE && $rose(SYS_RESET) |-> s_r.exit_flag && !s_r.deep_sleep_enable_bit)
    else $error("exit flags wrong after wake");
  a_bor_flag: assert property (CE && DEEP_SLEEP && evt[dswc_pkg::WK_BOR] |=> s_r.bor_flag)
    else $error("brown-out flag not set");
  a_bor_release: assert property (CE && DEEP_SLEEP && s_r.bor_en && evt[dswc_pkg::WK_BOR]
    |=> !s_r.held && s_r.ctx0 == '0)
    else $error("brown-out did not release pins");

  c_sleep_wake: cover property (DEEP_SLEEP ##1 SYS_RESET);
  c_ext_interrupt_pin_zero_wake: cover property (DEEP_SLEEP && ext_interrupt_pin_zero_hit);
  c_release: cover property (s_r.held ##1 !s_r.held && s_r.st == dswc_pkg::ST_RUN);
  c_bor_sleep: cover property (DEEP_SLEEP && s_r.bor_en && evt[dswc_pkg::WK_BOR]);
endmodule

/* dswc_wake_src.sv */
// Model of the outside wake sources: supply, watchdog, alarm, pins.
// Assumes sel is steady while fire is high for one cycle.
module dswc_wake_src (
  input wire logic clk,
  input wire logic [2:0] sel,
  input wire logic fire,
  output logic por,
  output logic wdt,
  output logic rtc,
  output logic master_clear_pin_n,
  output logic ext_interrupt_pin_zero,
  output logic bor
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_r = 3'h0;
  logic [2:0] sel_r = 3'h0;
  logic on;
  // Six cycles so the two-stage synchroniser cannot miss it
  always @(posedge clk)
  begin
    if (fire)
    begin
      sel_r <= sel;
      cnt_r <= 3'h6;
    end
    else if (cnt_r != 3'h0)
      cnt_r <= cnt_r - 3'h1;
  end
  assign on = cnt_r != 3'h0;
  assign por = on && sel_r == 3'(dswc_pkg::WK_POR);
  assign wdt = on && sel_r == 3'(dswc_pkg::WK_WDT);
  assign rtc = on && sel_r == 3'(dswc_pkg::WK_RTC);
  assign master_clear_pin_n = !(on && sel_r == 3'(dswc_pkg::WK_MASTER_CLEAR_PIN));
  assign ext_interrupt_pin_zero = on && sel_r == 3'(dswc_pkg::WK_EXT_INTERRUPT_PIN_ZERO);
  assign bor = on && sel_r == 3'(dswc_pkg::WK_BOR);
endmodule

/* deep_sleep_wake_control_tb_top.sv */
// Bench for the deep sleep wake control block over AXI4-Lite.
// Assumes the wake source model drives the asynchronous inputs.
module deep_sleep_wake_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, fire;
  logic awready, wready, bvalid, arready, rvalid, sys_rst, dslp, secondary_oscillator;
  logic por, wdt, rtc, master_clear_pin_n, ext_interrupt_pin_zero, bor;
  logic [7:0] awaddr, araddr, irq, pout, poe, dir, ndir;
  logic [31:0] wdata, rdata, x, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] sel;
  int n_mismatch = 0, compares = 0, seed = 75244;
  int i, n, s, wk, lost, seen;
  int src_t[9] = '{dswc_pkg::WK_WDT, dswc_pkg::WK_RTC, dswc_pkg::WK_RTC, dswc_pkg::WK_MASTER_CLEAR_PIN,
                   dswc_pkg::WK_EXT_INTERRUPT_PIN_ZERO, dswc_pkg::WK_POR, dswc_pkg::WK_BOR, dswc_pkg::WK_EXT_INTERRUPT_PIN_ZERO,
                   dswc_pkg::WK_EXT_INTERRUPT_PIN_ZERO};
  // Interrupt pin last: once disarmed, then armed at low polarity
  logic [3:0] cfg_t[9] = '{4'hf, 4'hf, 4'he, 4'hf, 4'hf, 4'hf, 4'hf, 4'h9, 4'hb};
  dswc_top i_dut (.CLK(clk), .RESET_N(reset_n), .CE(1'b1), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .POR_EVENT(por),
    .WDT_TIMEOUT(wdt), .RTC_ALARM(rtc), .MASTER_CLEAR_PIN_N(master_clear_pin_n), .EXT_INTERRUPT_PIN_ZERO(ext_interrupt_pin_zero), .BROWNOUT(bor),
    .IRQ_REQ(irq), .SYS_RESET(sys_rst), .DEEP_SLEEP(dslp), .SECONDARY_OSCILLATOR_EN(secondary_oscillator), .PIN_OUT(pout),
    .PIN_OE(poe));
  dswc_wake_src i_src (.clk(clk), .sel(sel), .fire(fire), .por(por), .wdt(wdt), .rtc(rtc),
    .master_clear_pin_n(master_clear_pin_n), .ext_interrupt_pin_zero(ext_interrupt_pin_zero), .bor(bor));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    compares++;
    if (v !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen %h exp %h", $time, v, e);
    end
  endtask
  // Refused sources other than brown-out are not recorded; master clear then ends the sleep
  function automatic logic [31:0] exp_wake(input int s, input int wk);
    exp_wake = (wk || s == dswc_pkg::WK_BOR) ? 32'(1 << s) : 32'h0;
    if (!wk)
      exp_wake = exp_wake | 32'(dswc_pkg::MASTER_CLEAR_PIN_INV);
  endfunction
  task end_sim;
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task tmo;
    n_mismatch++;
    $display("BAD t=%0t wait ran out", $time);
    end_sim();
  endtask
  // Ready is sampled at the falling edge; it is stable up to the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ra, rw, rb;
    logic [1:0] br;
    int k;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    rb = 0;
    for (k = 0; k < 40 && !rb; k++)
    begin
      @(negedge clk);
      ra = awvalid & awready;
      rw = wvalid & wready;
      rb = bvalid;
      br = bresp;
      @(posedge clk);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!rb) tmo();
    chk(br, dswc_pkg::RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    logic ra, got;
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    got = 0;
    for (k = 0; k < 40 && !got; k++)
    begin
      @(negedge clk);
      ra = arvalid & arready;
      got = rvalid;
      v = rdata;
      e = rresp;
      @(posedge clk);
      if (ra) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!got) tmo();
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] q;
    rd(a, v, q);
    chk(v, e);
  endtask
  task automatic go(input int k);
    @(posedge clk);
    sel <= 3'(k);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, fire, sel, irq, awaddr, araddr, wdata} = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rc(dswc_pkg::OFS_PIN_DIR, 32'h000000ff);
    rd(8'h40, d, r);
    chk(r, dswc_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    for (i = 0; i < 9; i++)
    begin
      s = src_t[i];
      wk = !(s == dswc_pkg::WK_BOR || (s == dswc_pkg::WK_RTC && !cfg_t[i][0])
             || (s == dswc_pkg::WK_EXT_INTERRUPT_PIN_ZERO && !cfg_t[i][1]));
      lost = s == dswc_pkg::WK_POR || s == dswc_pkg::WK_BOR;
      x = $random(seed);
      dir = x[23:16];
      ndir = ~dir;
      // Context kept here except on POR or brown-out wakes, as every cfg_t entry sets bor_en
      wr(dswc_pkg::OFS_CTX0, {16'h0, x[15:0]});
      wr(dswc_pkg::OFS_CFG, {28'h0, cfg_t[i]});
      wr(dswc_pkg::OFS_PIN_DIR, {24'h0, dir});
      wr(dswc_pkg::OFS_PIN_LAT, {24'h0, x[31:24]});
      wr(dswc_pkg::OFS_OSC_CTRL, 32'h2);
      irq <= x[7:0] | 8'h01;
      @(posedge clk);
      irq <= 8'h00;
      rc(dswc_pkg::OFS_IRQ_PEND, {24'h0, x[7:0] | 8'h01});
      wr(dswc_pkg::OFS_DS_CTRL, 32'h8000);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(dslp, 1'b1);
      chk(poe, ndir);
      chk(pout & poe, x[31:24] & ndir);
      rc(dswc_pkg::OFS_IRQ_PEND, 32'h0);
      rc(dswc_pkg::OFS_DS_CTRL, 32'h8001);
      go(s);
      if (!wk)
      begin
        seen = 0;
        for (n = 0; n < 12; n++)
        begin
          @(negedge clk);
          seen = seen | (sys_rst !== 1'b0);
        end
        chk(seen, 0);
        go(dswc_pkg::WK_MASTER_CLEAR_PIN);
      end
      n = 0;
      while (sys_rst !== 1'b1 && n < 20)
      begin
        @(negedge clk);
        n++;
      end
      if (n >= 20) tmo();
      n = 0;
      while (sys_rst === 1'b1 && n < 40)
      begin
        @(negedge clk);
        n++;
      end
      chk(n, 25);
      chk(secondary_oscillator, !lost);
      chk(poe, lost ? 8'h00 : ndir);
      rc(dswc_pkg::OFS_RST_CTRL, 32'h400);
      wr(dswc_pkg::OFS_RST_CTRL, 32'h0);
      rc(dswc_pkg::OFS_RST_CTRL, 32'h0);
      rc(dswc_pkg::OFS_WAKE_SRC, exp_wake(s, wk));
      rd(dswc_pkg::OFS_DS_CTRL, d, r);
      chk(d & (lost ? 32'h8002 : 32'h8003), (s == dswc_pkg::WK_BOR ? 2 : 0) | (lost ? 0 : 1));
      rc(dswc_pkg::OFS_CTX0, lost ? 32'h0 : {16'h0, x[15:0]});
      rc(dswc_pkg::OFS_PIN_DIR, 32'hff);
      rc(dswc_pkg::OFS_OSC_CTRL, 32'h0);
      // New direction must stay off the pins while they are held
      wr(dswc_pkg::OFS_PIN_DIR, {24'h0, ndir});
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(poe, lost ? dir : ndir);
      wr(dswc_pkg::OFS_OSC_CTRL, 32'h2);
      wr(dswc_pkg::OFS_DS_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(poe, dir);
      chk(secondary_oscillator, 1'b1);
    end
    end_sim();
  end
endmodule
